// *** adc_spi_command_config.v ***
// Function
// - Link uses clock mode 1: clock idles low, sample on falling edge.
// - Drive conversion_done_n low when a new result becomes available.
// - Command 06 performs a full reset of registers and conversion state.
// - Write: 40h plus address, count-minus-one, then data bytes to consecutive addresses.
// - Read: 20h plus address, count-minus-one, then consecutive register contents returned.
// - Command 08 starts converting; continuous mode keeps converting until stopped.
// - Command 12 then three no-op bytes shift out the 24-bit result.
// - Command 0A halts conversions, abandoning any one in progress.
// - Chip select low frames every command transaction; high ends it.
// - Rate-filter register value 24h selects 20 samples per second, FIR filter.
// - Conversion-control 01h selects continuous conversion, adding a 50 us delay to each conversion period.
// - Register at 05h value 00h: powered, no status or checksum, no timeout.
// - Reference register 1Ah selects internal reference, inputs 0 and 1.
// - Excitation routing 4Ah routes source two to input 4, one to common.
// - Excitation magnitude 44h sets both sources to 500 microamps.
// - Amplifier register 03h enables gain of 8.
// - Input select 34h picks input 2 positive, input 3 negative.
// - Input bias register 00h disables bias outputs and open-sensor currents.
// - Result is two's complement code, 2^23 times gain times input ratio.
`timescale 1ns/1ps
`default_nettype none
`include "adc_spi_defines.vh"

module adc_spi_command_config #(
   parameter [31:0] CONV_PERIOD = `CONV_PERIOD_DEFAULT,
   parameter [31:0] CONV_DELAY = `CONV_DELAY_CYCLES
) (
   input wire ref_clk,
   input wire rst,
   input wire sclk,
   input wire csN,
   input wire mosi,
   output reg misoOut,
   output reg misoOe,
   output reg conversion_done_n,
   input wire [23:0] sampleCode,
   output reg [7:0] rateFilterSelect,
   output reg [7:0] conversionControl,
   output reg [7:0] powerAndReadout,
   output reg [7:0] referenceSelect,
   output reg [7:0] excitationRouting,
   output reg [7:0] excitationMagnitude,
   output reg [7:0] amplifierGain,
   output reg [7:0] inputSelect,
   output reg [7:0] inputBiasControl,
   output reg converting
);
   localparam [2:0] ST_CMD = 3'd0;
   localparam [2:0] ST_WCOUNT = 3'd1;
   localparam [2:0] ST_WDATA = 3'd2;
   localparam [2:0] ST_RCOUNT = 3'd3;
   localparam [2:0] ST_RDATA = 3'd4;
   localparam [2:0] ST_RESULT = 3'd5;
   localparam [2:0] ST_IGNORE = 3'd6;

   wire sclkSync;
   wire csNSync;
   wire mosiSync;

   sync_two_flop syncClk (
      .clk(ref_clk),
      .rst(rst),
      .asyncIn(sclk),
      .syncOut(sclkSync)
   );
   sync_two_flop syncCs (
      .clk(ref_clk),
      .rst(rst),
      .asyncIn(csN),
      .syncOut(csNSync)
   );
   sync_two_flop syncMosi (
      .clk(ref_clk),
      .rst(rst),
      .asyncIn(mosi),
      .syncOut(mosiSync)
   );

   reg sclkPrev;
   reg [7:0] regFile [0:`REG_COUNT-1];
   reg [2:0] state;
   reg [7:0] shiftIn;
   reg [2:0] bitCount;
   reg [7:0] shiftOut;
   reg [4:0] regAddr;
   reg [4:0] bytesLeft;
   reg [23:0] resultHold;
   reg [23:0] resultOut;
   reg [4:0] resultBits;
   reg [31:0] convTimer;
   reg outLoaded;
   integer i;

   // Captured byte including the bit arriving on this falling edge
   wire sclkRise = sclkSync & ~sclkPrev;
   wire sclkFall = ~sclkSync & sclkPrev;
   wire [7:0] byteIn = {shiftIn[6:0], mosiSync};
   wire byteDone = sclkFall & (bitCount == 3'd7) & ~csNSync;
   wire continuous = regFile[`ADDR_CONVERSION_CONTROL][`CONV_CONTROL_CONTINUOUS_BIT];
   wire [31:0] convSpacing = continuous ? CONV_PERIOD + CONV_DELAY : CONV_PERIOD;
   wire convEnd = converting & (convTimer >= convSpacing - 32'd1);

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sclkPrev <= 1'b0;
         state <= ST_CMD;
         shiftIn <= 8'h00;
         bitCount <= 3'd0;
         shiftOut <= 8'h00;
         regAddr <= 5'd0;
         bytesLeft <= 5'd0;
         resultHold <= 24'h000000;
         resultOut <= 24'h000000;
         resultBits <= 5'd0;
         convTimer <= 32'd0;
         converting <= 1'b0;
         outLoaded <= 1'b0;
         misoOut <= 1'b0;
         misoOe <= 1'b0;
         conversion_done_n <= 1'b1;
         for (i = 0; i < `REG_COUNT; i = i + 1) begin
            regFile[i] <= `REG_RESET_VALUE;
         end
      end else begin
         sclkPrev <= sclkSync;
         misoOe <= ~csNSync;
         // Conversion engine; 08 starts it, 0A or a single shot stops it
         if (converting) begin
            if (convTimer >= convSpacing - 32'd1) begin
               convTimer <= 32'd0;
               resultHold <= sampleCode;
               conversion_done_n <= 1'b0;
               if (!continuous) begin
                  converting <= 1'b0;
               end
            end else begin
               convTimer <= convTimer + 32'd1;
            end
         end
         if (csNSync) begin
            // Deselect ends any transaction and rearms the byte framer
            state <= ST_CMD;
            bitCount <= 3'd0;
            outLoaded <= 1'b0;
         end else begin
            // Mode 1: drive on rising, sample on falling edge
            if (sclkRise) begin
               if (state == ST_RESULT) begin
                  misoOut <= resultOut[23];
                  resultOut <= {resultOut[22:0], 1'b0};
               end else begin
                  misoOut <= shiftOut[7];
                  shiftOut <= {shiftOut[6:0], 1'b0};
               end
            end
            if (sclkFall) begin
               shiftIn <= byteIn;
               bitCount <= bitCount + 3'd1;
            end
            if (byteDone) begin
               shiftOut <= 8'h00;
               case (state)
                  ST_CMD: begin
                     if (byteIn == `CMD_RESET) begin
                        converting <= 1'b0;
                        convTimer <= 32'd0;
                        conversion_done_n <= 1'b1;
                        for (i = 0; i < `REG_COUNT; i = i + 1) begin
                           regFile[i] <= `REG_RESET_VALUE;
                        end
                        state <= ST_IGNORE;
                     end else if (byteIn == `CMD_START) begin
                        converting <= 1'b1;
                        convTimer <= 32'd0;
                        state <= ST_IGNORE;
                     end else if (byteIn == `CMD_STOP) begin
                        converting <= 1'b0;
                        state <= ST_IGNORE;
                     end else if (byteIn == `CMD_READ_DATA) begin
                        resultOut <= resultHold;
                        resultBits <= 5'd0;
                        // A result finishing in this same cycle keeps the flag low
                        if (!convEnd) begin
                           conversion_done_n <= 1'b1;
                        end
                        state <= ST_RESULT;
                     end else if ((byteIn & `CMD_GROUP_MASK) == `CMD_REG_WRITE_BASE) begin
                        regAddr <= byteIn[4:0];
                        state <= ST_WCOUNT;
                     end else if ((byteIn & `CMD_GROUP_MASK) == `CMD_REG_READ_BASE) begin
                        regAddr <= byteIn[4:0];
                        state <= ST_RCOUNT;
                     end else begin
                        state <= ST_CMD;
                     end
                  end
                  ST_WCOUNT: begin
                     bytesLeft <= byteIn[4:0];
                     state <= ST_WDATA;
                  end
                  ST_WDATA: begin
                     // Configuration values steer the outputs below
                     regFile[regAddr] <= byteIn;
                     regAddr <= regAddr + 5'd1;
                     bytesLeft <= bytesLeft - 5'd1;
                     state <= (bytesLeft == 5'd0) ? ST_IGNORE : ST_WDATA;
                  end
                  ST_RCOUNT: begin
                     shiftOut <= regFile[regAddr];
                     regAddr <= regAddr + 5'd1;
                     bytesLeft <= byteIn[4:0];
                     state <= ST_RDATA;
                  end
                  ST_RDATA: begin
                     if (bytesLeft != 5'd0) begin
                        shiftOut <= regFile[regAddr];
                        regAddr <= regAddr + 5'd1;
                        bytesLeft <= bytesLeft - 5'd1;
                     end else begin
                        state <= ST_IGNORE;
                     end
                  end
                  ST_RESULT: begin
                     // Three no-op bytes carry out the 24 result bits
                     resultBits <= resultBits + 5'd8;
                     if (resultBits == 5'd16) begin
                        state <= ST_IGNORE;
                     end
                  end
                  ST_IGNORE: begin
                     state <= ST_IGNORE;
                  end
                  default: begin
                     state <= ST_CMD;
                  end
               endcase
            end
         end
         // While stopped with the flag idle, convTimer is held at zero
         if (!converting && conversion_done_n == 1'b1) begin
            convTimer <= 32'd0;
         end
      end
   end

   // Configuration outputs mirror the register file one cycle later
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rateFilterSelect <= `REG_RESET_VALUE;
         conversionControl <= `REG_RESET_VALUE;
         powerAndReadout <= `REG_RESET_VALUE;
         referenceSelect <= `REG_RESET_VALUE;
         excitationRouting <= `REG_RESET_VALUE;
         excitationMagnitude <= `REG_RESET_VALUE;
         amplifierGain <= `REG_RESET_VALUE;
         inputSelect <= `REG_RESET_VALUE;
         inputBiasControl <= `REG_RESET_VALUE;
      end else begin
         rateFilterSelect <= regFile[`ADDR_RATE_FILTER_SELECT];
         conversionControl <= regFile[`ADDR_CONVERSION_CONTROL];
         powerAndReadout <= regFile[`ADDR_POWER_AND_READOUT];
         referenceSelect <= regFile[`ADDR_REFERENCE_SELECT];
         excitationRouting <= regFile[`ADDR_EXCITATION_ROUTING];
         excitationMagnitude <= regFile[`ADDR_EXCITATION_MAGNITUDE];
         amplifierGain <= regFile[`ADDR_AMPLIFIER_GAIN];
         inputSelect <= regFile[`ADDR_INPUT_SELECT];
         inputBiasControl <= regFile[`ADDR_INPUT_BIAS_CONTROL];
      end
   end
endmodule

`default_nettype wire

// *** adc_spi_command_config_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_spi_command_config_monitor #(
   parameter [31:0] CONV_PERIOD = 32'd100,
   parameter [31:0] CONV_DELAY = 32'd10
) (
   input wire ref_clk,
   input wire rst,
   input wire sclk,
   input wire csN,
   input wire misoOut,
   input wire misoOe,
   input wire conversion_done_n,
   input wire [7:0] rateFilterSelect,
   input wire [7:0] amplifierGain,
   input wire converting
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_oe_drop: assert property ($rose(csN) |-> ##[1:4] !misoOe)
      else $error("oe held after deselect");
   a_oe_idle: assert property (csN [*5] |-> !misoOe)
      else $error("oe while deselected");
   a_miso_edge: assert property ($changed(misoOut) && misoOe && $past(misoOe) |-> sclk)
      else $error("miso moved with sclk low");
   a_start_frame: assert property ($rose(converting) |-> !csN)
      else $error("conversion began outside a frame");
   a_reg_frame: assert property ($changed(rateFilterSelect) || $changed(amplifierGain) |-> !csN)
      else $error("register moved outside a frame");
   a_done_rise: assert property ($rose(conversion_done_n) |-> !csN)
      else $error("done released outside a frame");
   a_done_cause: assert property ($fell(conversion_done_n) |-> $past(converting))
      else $error("done fell while idle");
   a_done_time: assert property ($rose(converting) && conversion_done_n |-> ##[1:1000] !conversion_done_n)
      else $error("no result after start");
   c_result: cover property ($fell(conversion_done_n));
   c_stop: cover property ($fell(converting));
   c_drive: cover property ($fell(csN) ##[1:200] misoOe);
endmodule
bind adc_spi_command_config adc_spi_command_config_monitor #(
   .CONV_PERIOD(CONV_PERIOD), .CONV_DELAY(CONV_DELAY)) mon (
   .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .csN(csN), .misoOut(misoOut), .misoOe(misoOe),
   .conversion_done_n(conversion_done_n), .rateFilterSelect(rateFilterSelect),
   .amplifierGain(amplifierGain), .converting(converting));
`default_nettype wire

// *** adc_spi_command_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module adc_spi_command_config_tb;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [23:0] sampleCode = 24'h000000;
   wire sclk, csN, mosi, misoOut, misoOe, conversion_done_n, converting, rxStrobe;
   wire [7:0] rxByte, rateFilterSelect, conversionControl, powerAndReadout, referenceSelect;
   wire [7:0] excitationRouting, excitationMagnitude, amplifierGain, inputSelect, inputBiasControl;
   integer fail_count = 0;
   integer n_tests = 0;
   integer seed = 32'h9DC1;
   integer i, w;
   logic [8:0] expQ[$];
   logic [8:0] e;
   logic [7:0] img[0:31];
   logic [7:0] rnd[$];
   logic [71:0] imgView;
   always #2.5 ref_clk = ~ref_clk;
   // Period longer than a read-data frame, so a fresh result never lands mid-read
   adc_spi_command_config #(.CONV_PERIOD(32'd900), .CONV_DELAY(32'd10)) dut (
      .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .csN(csN), .mosi(mosi), .misoOut(misoOut),
      .misoOe(misoOe), .conversion_done_n(conversion_done_n), .sampleCode(sampleCode),
      .rateFilterSelect(rateFilterSelect), .conversionControl(conversionControl),
      .powerAndReadout(powerAndReadout), .referenceSelect(referenceSelect),
      .excitationRouting(excitationRouting), .excitationMagnitude(excitationMagnitude),
      .amplifierGain(amplifierGain), .inputSelect(inputSelect),
      .inputBiasControl(inputBiasControl), .converting(converting));
   spi_host_model host (.ref_clk(ref_clk), .misoOut(misoOut), .sclk(sclk), .csN(csN),
      .mosi(mosi), .rxByte(rxByte), .rxStrobe(rxStrobe));
   always @(posedge ref_clk) if (rxStrobe) begin
      e = expQ.pop_front();
      if (e[8]) `CHK("miso byte", e[7:0], rxByte)
   end
   task automatic results;
      $display("checks %0d errors %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Bytes from index first on are compared against ex
   task automatic run(input logic [7:0] q[$], input integer first, input logic [7:0] ex[$]);
      foreach (q[k]) expQ.push_back(k >= first ? {1'b1, ex[k - first]} : 9'h000);
      host.frame(q);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d[$]);
      logic [7:0] f[$];
      f = {8'h40 | {3'b000, a}, 8'(d.size() - 1)};
      foreach (d[k]) begin
         f.push_back(d[k]);
         img[a + k] = d[k];
      end
      run(f, 99, d);
   endtask
   task automatic rd(input logic [4:0] a, input integer n);
      logic [7:0] f[$];
      logic [7:0] x[$];
      f = {8'h20 | {3'b000, a}, 8'(n - 1)};
      for (w = 0; w < n; w++) begin
         f.push_back(8'h00);
         x.push_back(img[a + w]);
      end
      run(f, 2, x);
   endtask
   task automatic regs;
      imgView = {img[2], img[3], img[5], img[6], img[13], img[14], img[16], img[17], img[18]};
      `CHK("regs", imgView, {rateFilterSelect, conversionControl, powerAndReadout, referenceSelect,
         excitationRouting, excitationMagnitude, amplifierGain, inputSelect, inputBiasControl})
   endtask
   task automatic waitLow;
      for (w = 0; w < 2000 && conversion_done_n !== 1'b0; w++) @(posedge ref_clk);
      if (conversion_done_n !== 1'b0) begin
         fail_count++;
         results;
      end
   endtask
   task automatic readData;
      run('{8'h12, 8'h00, 8'h00, 8'h00}, 1, '{sampleCode[23:16], sampleCode[15:8],
         sampleCode[7:0]});
      `CHK("done released", 1'b1, conversion_done_n)
   endtask
   initial begin
      repeat (100000) @(posedge ref_clk);
      fail_count++;
      results;
   end
   initial begin
      for (i = 0; i < 32; i++) img[i] = 8'h00;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (6) @(posedge ref_clk);
      regs;
      `CHK("done idle", 1'b1, conversion_done_n)
      run('{8'h06}, 99, '{8'h00});
      for (i = 0; i < 6; i++) rnd.push_back(8'($random(seed)));
      wr(5'h07, rnd);
      wr(5'h02, '{8'h24, 8'h01, 8'h00, 8'h00, 8'h1A});
      wr(5'h0D, '{8'h4A, 8'h44, 8'h00, 8'h03, 8'h34, 8'h00});
      regs;
      rd(5'h02, 17);
      sampleCode <= 24'($random(seed));
      run('{8'h08}, 99, '{8'h00});
      `CHK("converting", 1'b1, converting)
      waitLow;
      readData;
      waitLow;
      readData;
      run('{8'h0A}, 99, '{8'h00});
      `CHK("stopped", 1'b0, converting)
      run('{8'h06}, 99, '{8'h00});
      for (i = 0; i < 32; i++) img[i] = 8'h00;
      regs;
      results;
   end
endmodule
`default_nettype wire

// *** adc_spi_defines.vh ***
`ifndef ADC_SPI_DEFINES_VH
`define ADC_SPI_DEFINES_VH

// Command bytes
`define CMD_NOP 8'h00
`define CMD_RESET 8'h06
`define CMD_START 8'h08
`define CMD_STOP 8'h0A
`define CMD_READ_DATA 8'h12
`define CMD_REG_READ_BASE 8'h20
`define CMD_REG_WRITE_BASE 8'h40
`define CMD_GROUP_MASK 8'hE0
`define CMD_ADDR_MASK 8'h1F

// Register map
`define REG_COUNT 32
`define ADDR_RATE_FILTER_SELECT 5'h02
`define ADDR_CONVERSION_CONTROL 5'h03
`define ADDR_GENERAL_PIN_CONTROL 5'h04
`define ADDR_POWER_AND_READOUT 5'h05
`define ADDR_REFERENCE_SELECT 5'h06
`define ADDR_EXCITATION_ROUTING 5'h0D
`define ADDR_EXCITATION_MAGNITUDE 5'h0E
`define ADDR_RESERVED_SLOT 5'h0F
`define ADDR_AMPLIFIER_GAIN 5'h10
`define ADDR_INPUT_SELECT 5'h11
`define ADDR_INPUT_BIAS_CONTROL 5'h12

// Field positions
`define CONV_CONTROL_CONTINUOUS_BIT 0
`define RATE_FILTER_RATE_HI 7
`define RATE_FILTER_RATE_LO 3

// Reset value of every register
`define REG_RESET_VALUE 8'h00

// Sample data width
`define RESULT_WIDTH 24

// Conversion timing: one fixed period for every rate code, in ref_clk cycles (shortened model)
`define CONV_PERIOD_DEFAULT 32'd10000
// Fixed delay between continuous conversions, 50 us at 5 ns per cycle
`define CONV_DELAY_US 50
`define CLK_PERIOD_NS 5
`define CONV_DELAY_CYCLES ((`CONV_DELAY_US * 1000) / `CLK_PERIOD_NS)

`endif

// *** spi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input wire ref_clk,
   input wire misoOut,
   output logic sclk,
   output logic csN,
   output logic mosi,
   output logic [7:0] rxByte,
   output logic rxStrobe
);
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      mosi = 1'b0;
      rxByte = 8'h00;
      rxStrobe = 1'b0;
   end
   // 25 ref_clk cycles per sclk period gives the 125 ns link clock
   task automatic xfer(input logic [7:0] b);
      integer i;
      for (i = 7; i >= 0; i--) begin
         @(posedge ref_clk);
         sclk <= 1'b1;
         mosi <= b[i];
         repeat (12) @(posedge ref_clk);
         sclk <= 1'b0;
         rxByte[i] <= misoOut;
         repeat (12) @(posedge ref_clk);
      end
      rxStrobe <= 1'b1;
      @(posedge ref_clk);
      rxStrobe <= 1'b0;
   endtask
   task automatic frame(input logic [7:0] q[$]);
      @(posedge ref_clk);
      csN <= 1'b0;
      repeat (6) @(posedge ref_clk);
      foreach (q[k]) xfer(q[k]);
      repeat (6) @(posedge ref_clk);
      csN <= 1'b1;
      // Released data line must not keep looking valid
      mosi <= ~mosi;
      repeat (8) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// *** sync_two_flop.v ***
`timescale 1ns/1ps
`default_nettype none

module sync_two_flop (
   input wire clk,
   input wire rst,
   input wire asyncIn,
   output reg syncOut
);
   reg firstStage;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         firstStage <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         firstStage <= asyncIn;
         syncOut <= firstStage;
      end
   end
endmodule

`default_nettype wire
